//--- core/bbt_pkg.sv
// Constants, field layout and helpers for the beam blanking and teach configuration block.
// Assumes one clock domain and register access over AXI4-Lite with 32-bit data.
package bbt_pkg;

   localparam int          ADDR_W        = 12;
   localparam logic [11:0] REC_BLANK_IDX = 12'h04C;
   localparam logic [11:0] REC_TEACH_IDX = 12'h04F;
   localparam logic [11:0] ADDR_BLANK    = REC_BLANK_IDX << 2;
   localparam logic [11:0] ADDR_TEACH    = REC_TEACH_IDX << 2;
   localparam logic [11:0] ADDR_CTRL     = 12'h200;
   localparam logic [11:0] ADDR_STAT     = 12'h204;

   localparam int NUM_AREAS   = 4;
   localparam int BLANK_W     = 208;
   localparam int TEACH_W     = 32;
   localparam int FIELD_W     = 16;
   localparam int SEL_W       = 8;
   localparam int CNT_POS     = 200;
   localparam int AEN_POS     = 192;
   localparam int AREA1_POS   = 176;
   localparam int AREA_STRIDE = 48;
   localparam int START_OFS   = 16;
   localparam int END_OFS     = 32;
   localparam int STORE_POS   = 16;
   localparam int SENS_POS    = 8;
   localparam int BLANK_WORDS = 7;
   localparam int PAD_W       = 16;

   localparam logic [15:0] BEAM_MIN   = 16'h0001;
   localparam logic [15:0] BEAM_MAX   = 16'h06EE;
   localparam logic [15:0] SUB_NONE   = 16'h0000;
   localparam logic [15:0] SUB_ZERO   = 16'h0001;
   localparam logic [15:0] SUB_ONE    = 16'h0002;
   localparam logic [15:0] SUB_LOWER  = 16'h0003;
   localparam logic [15:0] SUB_HIGHER = 16'h0004;
   localparam logic [7:0]  AEN_MAX    = 8'h01;
   localparam logic [7:0]  CNT_MAX    = 8'h04;
   localparam logic [7:0]  STORE_MAX  = 8'h01;
   localparam logic [7:0]  SENS_MAX   = 8'h02;

   localparam logic [BLANK_W-1:0] BLANK_RESET =
      {8'h00, 8'h00, {4{16'h0000, 16'h0001, 16'h0001}}};
   localparam logic [TEACH_W-1:0] TEACH_RESET = 32'h0000_0000;

   localparam int CTRL_TEACH_BIT  = 0;
   localparam int CTRL_PTRCLR_BIT = 1;
   localparam int STAT_REJECT_BIT = 0;
   localparam int STAT_BUSY_BIT   = 2;
   localparam int STAT_WPTR_POS   = 4;
   localparam int STAT_RPTR_POS   = 8;
   localparam int STAT_AUTO_BIT   = 12;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   function automatic logic [15:0] area_code(input logic [BLANK_W-1:0] rec, input int k);
      return rec[AREA1_POS - AREA_STRIDE*k +: FIELD_W];
   endfunction : area_code

   function automatic logic [15:0] area_start(input logic [BLANK_W-1:0] rec, input int k);
      return rec[AREA1_POS - AREA_STRIDE*k - START_OFS +: FIELD_W];
   endfunction : area_start

   function automatic logic [15:0] area_end(input logic [BLANK_W-1:0] rec, input int k);
      return rec[AREA1_POS - AREA_STRIDE*k - END_OFS +: FIELD_W];
   endfunction : area_end

endpackage : bbt_pkg

//--- core/bbt_area_mask.sv
// One blanking area: which beams it covers and the value it substitutes.
// Assumes raw beams and area fields come from the same clock domain.
`timescale 1ns/100ps
module bbt_area_mask
   import bbt_pkg::*;
#(
   parameter int NUM_BEAMS = 1774
) (
   input  wire logic [15:0]          code,
   input  wire logic [15:0]          first,
   input  wire logic [15:0]          last,
   input  wire logic [NUM_BEAMS-1:0] beam_raw,
   output logic      [NUM_BEAMS-1:0] mask,
   output logic                      fill
);

   logic active;

   assign active = (code >= SUB_ZERO) && (code <= SUB_HIGHER);

   ////////////////////////////////////////////////////////////////////////////////
   // Beam coverage, beam numbers count from one
   for (genvar i = 0; i < NUM_BEAMS; i++) begin : g_beam
      assign mask[i] = active && (first <= 16'(i + 1)) && (16'(i + 1) <= last);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Substitute value, missing neighbour reads as zero
   always_comb begin
      fill = 1'b0;
      case (code)
         SUB_ZERO:   fill = 1'b0;
         SUB_ONE:    fill = 1'b1;
         SUB_LOWER: begin
            if (first > BEAM_MIN && int'(first) <= NUM_BEAMS + 1) begin
               fill = beam_raw[int'(first) - 2];
            end
         end
         SUB_HIGHER: begin
            if (int'(last) < NUM_BEAMS) begin
               fill = beam_raw[int'(last)];
            end
         end
         default:    fill = 1'b0;
      endcase
   end

endmodule : bbt_area_mask

//--- core/bbt_blanking_top.sv
// Blanking of the beam state vector with its configuration and teach option records.
// Assumes an AXI4-Lite master, raw beams and teach engine on aclk; panel key is a pin.
`timescale 1ns/100ps
module bbt_blanking_top
   import bbt_pkg::*;
#(
   parameter int NUM_BEAMS = 1774
) (
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
   input  wire logic [2:0]           s_axi_awprot,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   input  wire logic [ADDR_W-1:0]    s_axi_araddr,
   input  wire logic [2:0]           s_axi_arprot,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   input  wire logic [NUM_BEAMS-1:0] beam_raw,
   input  wire logic                 beam_valid_in,
   output logic [NUM_BEAMS-1:0]      beam_out,
   output logic                      beam_valid_out,
   input  wire logic                 teach_key_pin,
   output logic                      teach_req,
   output logic                      teach_nonvol,
   output logic [1:0]                teach_sens,
   input  wire logic                 learn_valid,
   input  wire logic [1:0]           learn_index,
   input  wire logic [15:0]          learn_start,
   input  wire logic [15:0]          learn_end,
   input  wire logic                 learn_done
);

   if (NUM_BEAMS < 1 || NUM_BEAMS > int'(BEAM_MAX)) begin : g_bad_beams
      $error("NUM_BEAMS outside the supported beam range");
   end

   logic [BLANK_W-1:0]         blank_reg;
   logic [TEACH_W-1:0]         teach_reg;
   logic [BLANK_W+PAD_W-1:0]   wstage_reg;
   logic [BLANK_W+PAD_W-1:0]   rshift_reg;
   logic [2:0]                 wptr_reg;
   logic [2:0]                 rptr_reg;
   logic [ADDR_W-1:0]          awaddr_reg;
   logic [31:0]                wdata_reg;
   logic [3:0]                 wstrb_reg;
   logic                       reject_reg;
   logic                       busy_reg;
   logic                       key_meta_reg;
   logic                       key_sync_reg;
   logic                       key_prev_reg;
   logic                       wr_go;
   logic                       rd_go;
   logic                       full_strb;
   logic                       blank_wr;
   logic                       blank_commit;
   logic                       teach_wr;
   logic                       ctrl_wr;
   logic                       stat_wr;
   logic                       rec_ok;
   logic                       teach_ok;
   logic                       teach_start;
   logic                       learn_ok;
   logic [BLANK_W-1:0]         wstage_next;
   logic [NUM_AREAS-1:0]       fill;
   logic [NUM_BEAMS-1:0]       mask [NUM_AREAS];
   logic [NUM_BEAMS-1:0]       beam_next;

   ////////////////////////////////////////////////////////////////////////////////
   // Record validation
   function automatic logic blank_valid(input logic [BLANK_W-1:0] rec);
      logic ok;
      ok = (rec[CNT_POS +: SEL_W] <= CNT_MAX) && (rec[AEN_POS +: SEL_W] <= AEN_MAX);
      for (int k = 0; k < NUM_AREAS; k++) begin
         ok = ok && (area_code(rec, k) <= SUB_HIGHER)
                 && (area_start(rec, k) >= BEAM_MIN) && (area_start(rec, k) <= BEAM_MAX)
                 && (area_end(rec, k) >= BEAM_MIN) && (area_end(rec, k) <= BEAM_MAX);
      end
      return ok;
   endfunction : blank_valid

   ////////////////////////////////////////////////////////////////////////////////
   // Write channel
   assign wr_go        = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   assign full_strb    = (wstrb_reg == 4'hF);
   assign blank_wr     = wr_go && full_strb && (awaddr_reg == ADDR_BLANK);
   assign teach_wr     = wr_go && full_strb && (awaddr_reg == ADDR_TEACH);
   assign ctrl_wr      = wr_go && full_strb && (awaddr_reg == ADDR_CTRL);
   assign stat_wr      = wr_go && full_strb && (awaddr_reg == ADDR_STAT);
   assign wstage_next  = {wstage_reg[BLANK_W-17:0], wdata_reg[31:PAD_W]};
   assign blank_commit = blank_wr && (wptr_reg == 3'(BLANK_WORDS - 1));
   assign rec_ok       = blank_valid(wstage_next);
   assign teach_ok     = (wdata_reg[STORE_POS +: SEL_W] <= STORE_MAX)
                         && (wdata_reg[SENS_POS +: SEL_W] <= SENS_MAX);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         awaddr_reg    <= '0;
         wdata_reg     <= '0;
         wstrb_reg     <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awaddr_reg    <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wdata_reg    <= s_axi_wdata;
            wstrb_reg    <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            if (!(blank_wr || teach_wr || ctrl_wr || stat_wr) && !full_strb) begin
               s_axi_bresp <= RESP_SLVERR;
            end else if (!(blank_wr || teach_wr || ctrl_wr || stat_wr)) begin
               s_axi_bresp <= RESP_DECERR;
            end else if ((blank_commit && !rec_ok) || (teach_wr && !teach_ok)) begin
               s_axi_bresp <= RESP_SLVERR;
            end else begin
               s_axi_bresp <= RESP_OKAY;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Blanking record staging and live record
   assign teach_start = (ctrl_wr && wdata_reg[CTRL_TEACH_BIT]) || (key_sync_reg && !key_prev_reg);
   assign learn_ok    = learn_valid && busy_reg && (blank_reg[AEN_POS +: SEL_W] == AEN_MAX)
                        && ({6'h00, learn_index} < blank_reg[CNT_POS +: SEL_W]);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wstage_reg <= '0;
         wptr_reg   <= '0;
      end else if (ctrl_wr && wdata_reg[CTRL_PTRCLR_BIT]) begin
         wptr_reg <= '0;
      end else if (blank_wr) begin
         wstage_reg <= {wstage_reg[BLANK_W+PAD_W-33:0], wdata_reg};
         wptr_reg   <= blank_commit ? 3'h0 : wptr_reg + 3'h1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         blank_reg <= BLANK_RESET;
      end else if (blank_commit && rec_ok) begin
         blank_reg <= wstage_next;
      end else if (teach_start && busy_reg == 1'b0
                   && blank_reg[AEN_POS +: SEL_W] == AEN_MAX) begin
         for (int k = 0; k < NUM_AREAS; k++) begin
            blank_reg[AREA1_POS - AREA_STRIDE*k +: FIELD_W] <= SUB_NONE;
         end
      end else if (learn_ok && learn_start >= BEAM_MIN && learn_start <= BEAM_MAX
                   && learn_end >= BEAM_MIN && learn_end <= BEAM_MAX) begin
         blank_reg[AREA1_POS - AREA_STRIDE*int'(learn_index) +: FIELD_W] <= SUB_ZERO;
         blank_reg[AREA1_POS - AREA_STRIDE*int'(learn_index) - START_OFS +: FIELD_W]
            <= learn_start;
         blank_reg[AREA1_POS - AREA_STRIDE*int'(learn_index) - END_OFS +: FIELD_W]
            <= learn_end;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Teach option record and teach control
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         teach_reg    <= TEACH_RESET;
         teach_nonvol <= (TEACH_RESET[STORE_POS +: SEL_W] == 8'h00);
         teach_sens   <= TEACH_RESET[SENS_POS +: 2];
      end else if (teach_wr && teach_ok) begin
         teach_reg    <= wdata_reg;
         teach_nonvol <= (wdata_reg[STORE_POS +: SEL_W] == 8'h00);
         teach_sens   <= wdata_reg[SENS_POS +: 2];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         key_meta_reg <= 1'b0;
         key_sync_reg <= 1'b0;
         key_prev_reg <= 1'b0;
      end else begin
         key_meta_reg <= teach_key_pin;
         key_sync_reg <= key_meta_reg;
         key_prev_reg <= key_sync_reg;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         teach_req <= 1'b0;
         busy_reg  <= 1'b0;
      end else begin
         teach_req <= teach_start && !busy_reg;
         if (teach_start && !busy_reg) begin
            busy_reg <= 1'b1;
         end else if (learn_done) begin
            busy_reg <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Reject flag, set wins over clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         reject_reg <= 1'b0;
      end else if ((blank_commit && !rec_ok) || (teach_wr && !teach_ok)) begin
         reject_reg <= 1'b1;
      end else if (stat_wr && wdata_reg[STAT_REJECT_BIT]) begin
         reject_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read channel
   assign rd_go = s_axi_arvalid && s_axi_arready;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= RESP_OKAY;
      end else if (rd_go) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= RESP_OKAY;
         s_axi_rdata   <= '0;
         if (s_axi_araddr == ADDR_BLANK) begin
            s_axi_rdata <= (rptr_reg == 3'h0) ? blank_reg[BLANK_W-1 -: 32]
                                              : rshift_reg[BLANK_W+PAD_W-1 -: 32];
         end else if (s_axi_araddr == ADDR_TEACH) begin
            s_axi_rdata <= teach_reg;
         end else if (s_axi_araddr == ADDR_CTRL) begin
            s_axi_rdata <= '0;
         end else if (s_axi_araddr == ADDR_STAT) begin
            s_axi_rdata[STAT_REJECT_BIT]        <= reject_reg;
            s_axi_rdata[STAT_BUSY_BIT]          <= busy_reg;
            s_axi_rdata[STAT_WPTR_POS +: 3]     <= wptr_reg;
            s_axi_rdata[STAT_RPTR_POS +: 3]     <= rptr_reg;
            s_axi_rdata[STAT_AUTO_BIT]          <= blank_reg[AEN_POS];
         end else begin
            s_axi_rresp <= RESP_DECERR;
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rptr_reg   <= '0;
         rshift_reg <= '0;
      end else if (ctrl_wr && wdata_reg[CTRL_PTRCLR_BIT]) begin
         rptr_reg <= '0;
      end else if (rd_go && s_axi_araddr == ADDR_BLANK) begin
         rptr_reg   <= (rptr_reg == 3'(BLANK_WORDS - 1)) ? 3'h0 : rptr_reg + 3'h1;
         rshift_reg <= (rptr_reg == 3'h0) ? {blank_reg[BLANK_W-33:0], 48'h0}
                                          : {rshift_reg[BLANK_W+PAD_W-33:0], 32'h0};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Beam substitution, area one has priority
   for (genvar k = 0; k < NUM_AREAS; k++) begin : g_area
      bbt_area_mask #(
         .NUM_BEAMS (NUM_BEAMS)
      ) u_area (
         .code     (area_code(blank_reg, k)),
         .first    (area_start(blank_reg, k)),
         .last     (area_end(blank_reg, k)),
         .beam_raw (beam_raw),
         .mask     (mask[k]),
         .fill     (fill[k])
      );
   end

   always_comb begin
      beam_next = beam_raw;
      for (int k = NUM_AREAS - 1; k >= 0; k--) begin
         for (int b = 0; b < NUM_BEAMS; b++) begin
            if (mask[k][b]) begin
               beam_next[b] = fill[k];
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         beam_out       <= '0;
         beam_valid_out <= 1'b0;
      end else begin
         beam_out       <= beam_next;
         beam_valid_out <= beam_valid_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_no_area_passthru;
      (area_code(blank_reg, 0) == SUB_NONE && area_code(blank_reg, 1) == SUB_NONE
       && area_code(blank_reg, 2) == SUB_NONE && area_code(blank_reg, 3) == SUB_NONE
       && !blank_commit) |=> (beam_out == $past(beam_raw));
   endproperty
   a_no_area_passthru: assert property (p_no_area_passthru)
      else $error("beams changed with no active area");

   property p_force_one;
      (area_code(blank_reg, 0) == SUB_ONE && !blank_commit
       && area_start(blank_reg, 0) <= area_end(blank_reg, 0)
       && int'(area_end(blank_reg, 0)) <= NUM_BEAMS)
         |=> beam_out[int'(area_start(blank_reg, 0)) - 1];
   endproperty
   a_force_one: assert property (p_force_one)
      else $error("forced one not applied");

   property p_start_range;
      area_start(blank_reg, 1) >= BEAM_MIN && area_end(blank_reg, 3) <= BEAM_MAX;
   endproperty
   a_start_range: assert property (p_start_range)
      else $error("beam number out of range");

   property p_manual_only;
      (learn_valid && blank_reg[AEN_POS +: SEL_W] != AEN_MAX && !blank_commit)
         |=> $stable(blank_reg);
   endproperty
   a_manual_only: assert property (p_manual_only)
      else $error("teach changed areas with auto blanking off");

   property p_count_cap;
      (learn_valid && {6'h00, learn_index} >= blank_reg[CNT_POS +: SEL_W] && !blank_commit)
         |=> $stable(blank_reg);
   endproperty
   a_count_cap: assert property (p_count_cap)
      else $error("teach exceeded area count");

   property p_commit;
      (blank_commit && rec_ok) |=> (blank_reg == $past(wstage_next)) && wptr_reg == 3'h0;
   endproperty
   a_commit: assert property (p_commit)
      else $error("blanking record not committed whole");

   property p_fields_legal;
      blank_reg[CNT_POS +: SEL_W] <= CNT_MAX && blank_reg[AEN_POS +: SEL_W] <= AEN_MAX;
   endproperty
   a_fields_legal: assert property (p_fields_legal)
      else $error("auto blanking fields illegal");

   property p_teach_rec;
      (teach_wr && !teach_ok) |=> $stable(teach_reg) && teach_sens <= 2'h2
                                  && s_axi_bresp == RESP_SLVERR;
   endproperty
   a_teach_rec: assert property (p_teach_rec)
      else $error("illegal teach record accepted");

   property p_beam_lat;
      beam_valid_in |=> beam_valid_out;
   endproperty
   a_beam_lat: assert property (p_beam_lat)
      else $error("beam output not one cycle behind");

   c_commit:    cover property (blank_commit && rec_ok);
   c_learn:     cover property (learn_ok);
   c_lower:     cover property (area_code(blank_reg, 0) == SUB_LOWER && beam_valid_out);
   c_rd_record: cover property (rd_go && s_axi_araddr == ADDR_BLANK && rptr_reg == 3'h6);

endmodule : bbt_blanking_top

//--- testbench/bbt_teach_model.sv
// Teach engine stand-in: answers each teach request with two learned areas, index 0 then index 1.
// Assumes the block's aclk and its one-cycle teach_req pulse.
`timescale 1ns/100ps
module bbt_teach_model #(
   parameter logic [15:0] AREA_S = 16'h0003,
   parameter logic [15:0] AREA_E = 16'h0005
) (
   input  wire logic aclk,
   input  wire logic teach_req,
   output logic      learn_valid = 1'b0,
   output logic [1:0] learn_index = 2'h0,
   output logic [15:0] learn_start = 16'h0000,
   output logic [15:0] learn_end = 16'h0000,
   output logic      learn_done = 1'b0
);
   logic [3:0] sh = 4'h0;
   // Fields toggle while unqualified
   always @(posedge aclk) begin
      sh <= {sh[2:0], teach_req === 1'b1};
      learn_valid <= sh[2] | sh[3];
      learn_done <= sh[3];
      learn_index <= sh[2] ? 2'h0 : sh[3] ? 2'h1 : ~learn_index;
      learn_start <= sh[2] | sh[3] ? AREA_S : ~learn_start;
      learn_end <= sh[2] | sh[3] ? AREA_E : ~learn_end;
   end
endmodule : bbt_teach_model

//--- testbench/test_bbt_blanking_top.sv
// Self-checking bench: register records over AXI4-Lite, beam blanking, auto teach.
// Assumes 16 beams and the teach engine stand-in.
`timescale 1ns/100ps
module test_bbt_blanking_top
   import bbt_pkg::*;
;
   localparam logic [207:0] R1 = {16'h0000, 48'h0002_000A_000C, 48'h0001_0004_0006,
      48'h0003_0002_0003, 48'h0004_0003_000E};
   localparam logic [207:0] R3 = {16'h0101, 48'h0001_0003_0005, 16'h0000, R1[127:96],
      16'h0000, R1[79:48], 16'h0000, R1[31:0]};
   logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
   logic [11:0] awa = 0, ara = 0;
   logic [31:0] wd = 0, seed = 79;
   logic [15:0] raw = 0, bo;
   logic bvi = 0, key = 0, awr, wr_, bv, arr, rv, bvo, treq, tnv, lv, ld;
   logic [1:0] br, rr, ts, li;
   logic [31:0] rd_;
   logic [15:0] ls, le;
   logic [33:0] rq[$], bq[$];
   int bad_count = 0, num_checks = 0, n_teach = 0;
   always #4 aclk = ~aclk;
   bbt_blanking_top #(.NUM_BEAMS(16)) dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
      .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(br),
      .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
      .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd_), .s_axi_rresp(rr),
      .s_axi_rvalid(rv), .s_axi_rready(rry), .beam_raw(raw), .beam_valid_in(bvi),
      .beam_out(bo), .beam_valid_out(bvo), .teach_key_pin(key), .teach_req(treq),
      .teach_nonvol(tnv), .teach_sens(ts), .learn_valid(lv), .learn_index(li),
      .learn_start(ls), .learn_end(le), .learn_done(ld));
   bbt_teach_model tm (.aclk(aclk), .teach_req(treq), .learn_valid(lv), .learn_index(li),
      .learn_start(ls), .learn_end(le), .learn_done(ld));
   ////////////////////////////////////////////////////////////////////////////////
   task check(input logic [33:0] got, input logic [33:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task report_and_stop;
      if (bad_count == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : report_and_stop
   task to(input int n);
      if (n >= 50) begin
         bad_count++;
         report_and_stop();
      end
   endtask : to
   function logic [31:0] xs;
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs
   function automatic logic [15:0] blank(logic [15:0] r, logic [207:0] c);
      logic [15:0] o, cd, s, e;
      o = r;
      for (int k = 3; k >= 0; k--) begin
         cd = c[176-48*k+:16];
         s = c[160-48*k+:16];
         e = c[144-48*k+:16];
         for (int b = 0; b < 16; b++) if (cd != 0 && b + 1 >= s && b + 1 <= e)
            o[b] = cd == 1 ? 1'b0 : cd == 2 ? 1'b1 : cd == 3 ? s > 1 && r[s-2] : e < 16 && r[e];
      end
      return o;
   endfunction : blank
   task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
      int n;
      @(posedge aclk);
      awa <= a;
      wd <= d;
      awv <= 1;
      wv <= 1;
      bry <= 1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (awr) awv <= 0;
         if (wr_) wv <= 0;
      end while (bv !== 1 && n < 50);
      bry <= 0;
      to(n);
      check(br, r);
   endtask : wr
   task rd(input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge aclk);
      rq.push_back({RESP_OKAY, d});
      ara <= a;
      arv <= 1;
      rry <= 1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (arr) arv <= 0;
      end while (rv !== 1 && n < 50);
      rry <= 0;
      to(n);
   endtask : rd
   task wrec(input logic [207:0] c, input logic [1:0] r7);
      logic [223:0] t;
      t = {c, 16'h0000};
      wr(ADDR_CTRL, 32'h2, RESP_OKAY);
      for (int i = 0; i < 7; i++) wr(ADDR_BLANK, t[223-32*i-:32], i == 6 ? r7 : RESP_OKAY);
   endtask : wrec
   task rdrec(input logic [207:0] c);
      logic [223:0] t;
      t = {c, 16'h0000};
      wr(ADDR_CTRL, 32'h2, RESP_OKAY);
      for (int i = 0; i < 7; i++) rd(ADDR_BLANK, t[223-32*i-:32]);
   endtask : rdrec
   task beams(input logic [207:0] c);
      logic [31:0] x;
      repeat (10) begin
         @(posedge aclk);
         x = xs();
         raw <= x[15:0];
         bvi <= 1;
         bq.push_back({18'h0, blank(x[15:0], c)});
      end
      @(posedge aclk);
      bvi <= 0;
      repeat (3) @(posedge aclk);
   endtask : beams
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge aclk) if (rv === 1 && rry === 1) check({rr, rd_}, rq.pop_front());
   always @(posedge aclk) if (bvo === 1) check(bo, bq.pop_front());
   always @(posedge aclk) if (treq === 1) n_teach++;
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1;
      rdrec(BLANK_RESET);
      rd(ADDR_TEACH, 32'h0);
      check(tnv, 1);
      wr(ADDR_TEACH, 32'h0001_0200, RESP_OKAY);
      rd(ADDR_TEACH, 32'h0001_0200);
      check(ts, 2);
      check(tnv, 0);
      wr(ADDR_TEACH, 32'h0003_0000, RESP_SLVERR);
      rd(ADDR_STAT, 32'h1);
      wr(ADDR_STAT, 32'h1, RESP_OKAY);
      rd(ADDR_STAT, 32'h0);
      wr(12'h100, 32'h1, RESP_DECERR);
      wrec(R1, RESP_OKAY);
      rdrec(R1);
      beams(R1);
      wrec({16'h0000, 16'h0005, R1[175:0]}, RESP_SLVERR);
      rdrec(R1);
      wrec({16'h0101, R1[191:0]}, RESP_OKAY);
      wr(ADDR_CTRL, 32'h1, RESP_OKAY);
      repeat (10) @(posedge aclk);
      check(n_teach, 1);
      rdrec(R3);
      beams(R3);
      wrec({16'h0100, R3[191:0]}, RESP_OKAY);
      @(posedge aclk);
      key <= 1;
      repeat (12) @(posedge aclk);
      key <= 0;
      check(n_teach, 2);
      rdrec({16'h0100, R3[191:0]});
      report_and_stop();
   end
endmodule : test_bbt_blanking_top
